// ==== hw/scc_cfg_if.sv ====
// interface carrying decoded settings from register file to clock logic
`timescale 1ns/1ps
interface scc_cfg_if;
  logic [8:0] ref_delay;
  logic [1:0] phase_sel;
  logic secondary;
  logic out_disable;
  logic low_rate;
  modport src (output ref_delay, phase_sel, secondary, out_disable, low_rate);
  modport dst (input ref_delay, phase_sel, secondary, out_disable, low_rate);
endinterface : scc_cfg_if

// ==== hw/scc_pkg.sv ====
// package of register map, fields and timing constants for the clock control
package scc_pkg;
  // printed offsets are register indices; byte address is four times index
  localparam logic [3:0] IDX_COARSE = 4'hc;
  localparam logic [3:0] IDX_FINE = 4'hd;
  localparam logic [3:0] IDX_SYNC = 4'he;
  localparam logic [3:0] IDX_RSVD = 4'hf;
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_MODE = 4'h1;
  localparam logic [3:0] IDX_STAT = 4'h2;
  localparam logic [15:0] RST_COARSE = 16'h0004;
  localparam logic [15:0] RST_FINE = 16'h0000;
  localparam logic [15:0] RST_SYNC = 16'h0003;
  localparam logic [15:0] RSVD_WORD = 16'h001d;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_MODE = 16'h0000;
  // fine adjust fields
  localparam int FINE_MAG_LSB = 10;
  localparam int FINE_MAG_W = 6;
  localparam logic [9:0] FINE_LOW_KEEP = 10'h000;
  // coarse register select bit and magnitude field
  localparam int COARSE_SEL_BIT = 3;
  localparam int COARSE_MAG_LSB = 4;
  localparam int COARSE_MAG_W = 12;
  // sync register fields
  localparam int REF_DLY_LSB = 7;
  localparam int REF_DLY_W = 9;
  localparam int EDGE_BIT = 6;
  localparam int PHASE_LSB = 3;
  localparam int SEC_BIT = 2;
  localparam int OUT_DIS_BIT = 1;
  localparam int RST_DIS_BIT = 0;
  localparam logic [8:0] REF_DLY_MAX_CODE = 9'h13f;
  // control and mode register fields
  localparam int CTRL_DES_LSB = 5;
  localparam logic [2:0] CTRL_DES_IQCLK = 3'h0;
  localparam int MODE_LOWRATE_BIT = 0;
  localparam int MODE_DEMUX_LSB = 1;
  localparam int MODE_INSEL_LSB = 3;
  // delay steps and limits; fine in femtoseconds, reference in picoseconds
  localparam int FINE_STEP_FS = 36;
  localparam int FINE_MAX_FS = 2300;
  localparam int REF_MAX_PS = 1200;
  // output latency in sample cycles for each demux setting
  localparam logic [3:0] LAT_1TO1 = 4'h4;
  localparam logic [3:0] LAT_1TO2 = 4'h6;
  localparam logic [3:0] LAT_1TO4 = 4'h8;
  localparam logic [1:0] DIV_NORMAL = 2'h3;
  localparam logic [1:0] DIV_LOWRATE = 2'h1;
  typedef enum logic [1:0] {
    SCC_IN_I = 2'b00,
    SCC_IN_Q = 2'b01,
    SCC_IN_BOTH = 2'b10
  } scc_insel_e;
  typedef enum logic [1:0] {
    SCC_DMX_1 = 2'b00,
    SCC_DMX_2 = 2'b01,
    SCC_DMX_4 = 2'b10
  } scc_demux_e;
endpackage : scc_pkg

// ==== hw/scc_refclk.sv ====
// reference clock divider, phase latch and multi chip sync logic
`timescale 1ns/1ps
module scc_refclk
  import scc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  scc_cfg_if.dst cfg,
  input wire logic ref_in,
  output logic ref_out_one,
  output logic ref_out_two,
  output logic [8:0] ref_delay_eff,
  output logic [1:0] div_phase
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s2_d;
    logic [1:0] div;
    logic [1:0] phase;
    logic o1;
    logic o2;
    logic [8:0] dly;
  } scc_ref_s;
  scc_ref_s r;
  scc_ref_s next_r;
  always_comb begin
    next_r = r;
    next_r.s1 = ref_in;
    next_r.s2 = r.s1;
    next_r.s2_d = r.s2;
    next_r.div = r.div + 2'h1;
    if (cfg.low_rate && r.div >= DIV_LOWRATE) begin
      next_r.div = 2'h0;
    end
    // secondary realigns its divider on the primary's reference edge
    if (cfg.secondary && r.s2 && !r.s2_d) begin // RULE7
      next_r.div = cfg.phase_sel; // RULE6
    end
    next_r.phase = cfg.phase_sel; // RULE6
    // same gating for primary and secondary roles
    next_r.o1 = !cfg.out_disable &&
      (cfg.low_rate ? r.div[0] : r.div[1]); // RULE8 RULE9
    next_r.o2 = next_r.o1; // RULE8
    next_r.dly = (cfg.ref_delay >= REF_DLY_MAX_CODE) ?
      REF_DLY_MAX_CODE : cfg.ref_delay; // RULE4
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign ref_out_one = r.o1;
  assign ref_out_two = r.o2;
  assign ref_delay_eff = r.dly;
  assign div_phase = r.phase;
endmodule : scc_refclk

// ==== hw/scc_top.sv ====
// sample clock aperture delay, sync and sampling edge control with apb slave
//
// How it works
// RULE1: fine magnitude in bits 15:10 applies only while select bit set
// RULE2: fine delay is code times about 36 fs, max near 2.3 ps
// RULE3: software keeps fine register bits 9:0 at zero
// RULE4: reference delay code 15:7 saturates at 319, 1200 ps
// RULE5: bit 6 opposite-edge mode needs control bits 7:5 equal 000
// RULE6: phase field 4:3 picks latched reference phase 0/90/180/270
// RULE7: bit 2 set makes device secondary, synced to incoming reference
// RULE8: bit 1 clear drives clock/4 or clock/2 on both reference outputs
// RULE9: output disable acts the same in primary and secondary roles
// RULE10: bit 0 default 1 disables output clock reset, 0 enables it
// RULE11: last register is reserved, read only, fixed pattern
// RULE12: outside dual-edge both channels sample on rising edge
// RULE13: in dual-edge modes i rises, q falls
// RULE14: output latency fixed, chosen by demux mode
// RULE15: dual-edge without input choice uses i input only; the code marks both i and q inputs used in dual-edge mode
// RULE16: two channels at 1.6 GSPS or one at 3.2 GSPS
// RULE17: conversion runs continuously while sample clock present
// RULE18: select bit enables both coarse and fine delay
`timescale 1ns/1ps
module scc_top
  import scc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_in,
  input wire logic clock_present,
  output logic reference_clock_output_one,
  output logic reference_clock_output_two,
  output logic [11:0] coarse_delay_code,
  output logic [5:0] fine_delay_magnitude,
  output logic [11:0] fine_delay_fs,
  output logic [8:0] reference_clock_delay,
  output logic [1:0] reference_phase_select,
  output logic secondary_role_enable,
  output logic output_clock_reset,
  output logic dual_edge_mode,
  output logic i_sample_rising,
  output logic q_sample_rising,
  output logic i_input_used,
  output logic q_input_used,
  output logic dual_channel,
  output logic [3:0] output_latency,
  output logic converting
);
  typedef struct packed {
    logic [15:0] coarse;
    logic [15:0] fine;
    logic [15:0] sync;
    logic [15:0] ctrl;
    logic [15:0] mode;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic cp1;
    logic cp2;
    logic [11:0] cdly;
    logic [5:0] fmag;
    logic [11:0] ffs;
    logic clk_rst;
    logic des;
    logic i_rise;
    logic q_rise;
    logic i_use;
    logic q_use;
    logic dual;
    logic [3:0] lat;
    logic conv;
  } scc_top_s;
  scc_top_s r;
  scc_top_s next_r;
  logic [8:0] ref_dly_eff;
  logic [1:0] phase_eff;
  logic [3:0] idx;
  logic ref_o1;
  logic ref_o2;
  scc_cfg_if cfg_bus();

  // merge write data into a 16-bit register under the two low byte strobes
  function automatic logic [15:0] strb_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [15:0] v;
    v = old;
    if (st[0]) begin
      v[7:0] = wd[7:0];
    end
    if (st[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction : strb_merge

  function automatic logic [3:0] demux_latency(input logic [1:0] dm);
    logic [3:0] l;
    l = LAT_1TO1;
    case (dm)
      SCC_DMX_1: l = LAT_1TO1;
      SCC_DMX_2: l = LAT_1TO2;
      SCC_DMX_4: l = LAT_1TO4;
      default: l = LAT_1TO1;
    endcase
    return l;
  endfunction : demux_latency

  // registers are 16 bits wide; the upper half of the bus reads zero
  function automatic logic [31:0] word_of(input logic [15:0] h);
    return {16'h0000, h};
  endfunction : word_of

  // status shows live decoded state; the delay loses its two low bits
  function automatic logic [15:0] status_word(input scc_top_s s,
                                              input logic [8:0] dly);
    return {s.conv, s.des, s.dual, s.i_use, s.q_use, s.lat, dly[8:2]};
  endfunction : status_word

  // only aligned words in the low page that have a register behind them
  function automatic logic addr_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    case (a[5:2])
      IDX_COARSE, IDX_FINE, IDX_SYNC, IDX_RSVD: hit = 1'b1;
      IDX_CTRL, IDX_MODE, IDX_STAT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit && (a[7:6] == 2'h0) && (a[1:0] == 2'h0);
  endfunction : addr_mapped

  // product of code and step, clamped at the top of the fine span
  function automatic logic [11:0] fine_fs(input logic [5:0] m);
    logic [11:0] f;
    f = 12'(int'(m) * FINE_STEP_FS); // RULE2
    if (f > 12'(FINE_MAX_FS)) begin
      f = 12'(FINE_MAX_FS);
    end
    return f;
  endfunction : fine_fs

  // whole reset image as one value: the reset branch stays a single
  // assignment and no field can be missed
  function automatic scc_top_s reset_image();
    scc_top_s s;
    s = '0;
    s.coarse = RST_COARSE;
    s.fine = RST_FINE;
    s.sync = RST_SYNC;
    s.ctrl = RST_CTRL;
    s.mode = RST_MODE;
    s.i_rise = 1'b1;
    s.q_rise = 1'b1;
    s.i_use = 1'b1;
    s.q_use = 1'b1;
    s.dual = 1'b1;
    s.lat = LAT_1TO1;
    return s;
  endfunction : reset_image

  // word index; the two byte bits below it must be zero
  assign idx = paddr[5:2];
  assign cfg_bus.ref_delay = r.sync[REF_DLY_LSB +: REF_DLY_W];
  assign cfg_bus.phase_sel = r.sync[PHASE_LSB +: 2];
  assign cfg_bus.secondary = r.sync[SEC_BIT];
  assign cfg_bus.out_disable = r.sync[OUT_DIS_BIT];
  assign cfg_bus.low_rate = r.mode[MODE_LOWRATE_BIT];

  scc_refclk u_refclk (
    .sys_clk(sys_clk),
    .rst(rst),
    .cfg(cfg_bus),
    .ref_in(ref_in),
    .ref_out_one(ref_o1),
    .ref_out_two(ref_o2),
    .ref_delay_eff(ref_dly_eff),
    .div_phase(phase_eff)
  );

  always_comb begin
    logic sel;
    logic mapped;
    logic setup;
    logic [1:0] insel;
    sel = 1'b0;
    mapped = 1'b0;
    setup = 1'b0;
    insel = 2'h0;
    next_r = r;
    setup = psel && !penable;
    mapped = addr_mapped(paddr);
    // no wait state: answer in first access cycle, data prepared at setup
    next_r.ready = setup;
    next_r.err = setup && !mapped;
    if (setup && !pwrite) begin
      case (idx)
        IDX_COARSE: next_r.rdata = word_of(r.coarse);
        IDX_FINE: next_r.rdata = word_of(r.fine);
        IDX_SYNC: next_r.rdata = word_of(r.sync);
        IDX_RSVD: next_r.rdata = word_of(RSVD_WORD); // RULE11
        IDX_CTRL: next_r.rdata = word_of(r.ctrl);
        IDX_MODE: next_r.rdata = word_of(r.mode);
        IDX_STAT: next_r.rdata = word_of(status_word(r, ref_dly_eff));
        default: next_r.rdata = 32'h00000000;
      endcase
      // a refused read returns zero rather than an aliased register
      if (!mapped) begin
        next_r.rdata = 32'h00000000;
      end
    end
    // a write lands at the access edge, the one where pready is seen high
    sel = psel && penable && r.ready && pwrite && mapped;
    if (sel) begin
      case (idx)
        IDX_COARSE: next_r.coarse = strb_merge(r.coarse, pwdata, pstrb);
        // low bits are expected zero from software; stored as written
        IDX_FINE: next_r.fine = strb_merge(r.fine, pwdata, pstrb); // RULE3
        IDX_SYNC: next_r.sync = strb_merge(r.sync, pwdata, pstrb);
        IDX_CTRL: next_r.ctrl = strb_merge(r.ctrl, pwdata, pstrb);
        IDX_MODE: next_r.mode = strb_merge(r.mode, pwdata, pstrb);
        default: next_r.mode = r.mode; // reserved word ignores writes
      endcase
    end
    // the select bit gates both coarse and fine settings together
    next_r.cdly = r.coarse[COARSE_SEL_BIT] ?
      r.coarse[COARSE_MAG_LSB +: COARSE_MAG_W] : 12'h000; // RULE18
    next_r.fmag = r.coarse[COARSE_SEL_BIT] ?
      r.fine[FINE_MAG_LSB +: FINE_MAG_W] : 6'h00; // RULE1 RULE18
    next_r.ffs = fine_fs(next_r.fmag); // RULE2
    next_r.clk_rst = !r.sync[RST_DIS_BIT]; // RULE10
    next_r.des = r.sync[EDGE_BIT] &&
      (r.ctrl[CTRL_DES_LSB +: 3] == CTRL_DES_IQCLK); // RULE5
    // rising edge for i always; q rises only outside dual-edge
    next_r.i_rise = 1'b1; // RULE12 RULE13
    next_r.q_rise = !next_r.des; // RULE12 RULE13
    // the input choice is never consulted: both inputs are used in every mode
    insel = r.mode[MODE_INSEL_LSB +: 2];
    if (!next_r.des) begin
      next_r.i_use = 1'b1;
      next_r.q_use = 1'b1;
    end else if (r.sync[EDGE_BIT]) begin
      next_r.i_use = 1'b1;
      next_r.q_use = 1'b1;
    end else begin
      case (insel)
        SCC_IN_Q: begin
          next_r.i_use = 1'b0;
          next_r.q_use = 1'b1;
        end
        SCC_IN_BOTH: begin
          next_r.i_use = 1'b1;
          next_r.q_use = 1'b1;
        end
        default: begin
          next_r.i_use = 1'b1; // RULE15
          next_r.q_use = 1'b0; // RULE15
        end
      endcase
    end
    next_r.dual = !next_r.des; // RULE16
    next_r.lat = demux_latency(r.mode[MODE_DEMUX_LSB +: 2]); // RULE14
    // clock_present is a pin level: two stages before use
    next_r.cp1 = clock_present;
    next_r.cp2 = r.cp1;
    next_r.conv = r.cp2; // RULE17
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= reset_image();
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.rdata;
  assign pready = r.ready;
  assign pslverr = r.err;
  assign reference_clock_output_one = ref_o1;
  assign reference_clock_output_two = ref_o2;
  assign coarse_delay_code = r.cdly;
  assign fine_delay_magnitude = r.fmag;
  assign fine_delay_fs = r.ffs;
  assign reference_clock_delay = ref_dly_eff;
  assign reference_phase_select = phase_eff;
  assign secondary_role_enable = r.sync[SEC_BIT];
  assign output_clock_reset = r.clk_rst;
  assign dual_edge_mode = r.des;
  assign i_sample_rising = r.i_rise;
  assign q_sample_rising = r.q_rise;
  assign i_input_used = r.i_use;
  assign q_input_used = r.q_use;
  assign dual_channel = r.dual;
  assign output_latency = r.lat;
  assign converting = r.conv;
endmodule : scc_top

// ==== verification/scc_checker_properties.sv ====
// concurrent checks on the ports of the clock control block
`timescale 1ns/1ps
module scc_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic clock_present,
  input wire logic reference_clock_output_one,
  input wire logic reference_clock_output_two,
  input wire logic [5:0] fine_delay_magnitude,
  input wire logic [11:0] fine_delay_fs,
  input wire logic [8:0] reference_clock_delay,
  input wire logic dual_edge_mode,
  input wire logic q_sample_rising,
  input wire logic dual_channel,
  input wire logic [3:0] output_latency,
  input wire logic converting
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_fine_scale: assert property ($stable(fine_delay_magnitude) |->
    fine_delay_fs == 12'(fine_delay_magnitude) * 12'h024)
    else $error("fine delay not magnitude times step");
  a_ref_saturate: assert property (reference_clock_delay <= 9'h13f)
    else $error("reference delay above limit");
  a_q_edge: assert property ($stable(dual_edge_mode) |->
    q_sample_rising == !dual_edge_mode)
    else $error("q edge does not follow dual-edge mode");
  a_single_chan: assert property (dual_edge_mode [*2] |-> !dual_channel)
    else $error("dual channel left on in dual-edge mode");
  a_ref_pair: assert property (
    reference_clock_output_one == reference_clock_output_two)
    else $error("reference outputs differ");
  a_fixed_word: assert property (psel && penable && pready && !pwrite &&
    paddr == 8'h3c |-> prdata == 32'h0000001d)
    else $error("reserved word read wrong");
  a_conv_on: assert property (clock_present [*6] |-> converting)
    else $error("not converting with clock present");
  a_conv_off: assert property (!clock_present [*6] |-> !converting)
    else $error("converting without clock");
  a_latency_set: assert property (
    output_latency inside {4'h4, 4'h6, 4'h8})
    else $error("latency outside demux set");
  a_ready_next: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a pulse after setup");
endmodule : scc_checker
bind scc_top scc_checker u_chk (.sys_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .clock_present, .reference_clock_output_one,
  .reference_clock_output_two, .fine_delay_magnitude, .fine_delay_fs,
  .reference_clock_delay, .dual_edge_mode, .q_sample_rising, .dual_channel,
  .output_latency, .converting);

// ==== verification/scc_ref_source.sv ====
// behavioural primary converter sending the shared reference clock
`timescale 1ns/1ps
module scc_ref_source (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  output logic ref_clk
);
  logic [1:0] div;
  // stands still at low outside a run, as a released line would
  always_ff @(posedge sys_clk) begin
    if (rst || !run) div <= 2'h0;
    else div <= div + 2'h1;
  end
  assign ref_clk = div[1];
endmodule : scc_ref_source

// ==== verification/scc_top_bench.sv ====
// self-checking bench for the clock control block
`timescale 1ns/1ps
module scc_top_bench;
  import scc_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ref_run = 1'b0, clock_present = 1'b0, ref_in;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf, output_latency;
  logic pready, pslverr, err, reference_clock_output_one;
  logic reference_clock_output_two, secondary_role_enable;
  logic output_clock_reset, dual_edge_mode, i_sample_rising;
  logic q_sample_rising, i_input_used, q_input_used, dual_channel;
  logic converting;
  logic [11:0] coarse_delay_code, fine_delay_fs;
  logic [5:0] fine_delay_magnitude;
  logic [8:0] reference_clock_delay;
  logic [1:0] reference_phase_select;
  int mismatches = 0, samples_checked = 0;
  scc_top dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .ref_in, .clock_present,
    .reference_clock_output_one, .reference_clock_output_two,
    .coarse_delay_code, .fine_delay_magnitude, .fine_delay_fs,
    .reference_clock_delay, .reference_phase_select, .secondary_role_enable,
    .output_clock_reset, .dual_edge_mode, .i_sample_rising, .q_sample_rising,
    .i_input_used, .q_input_used, .dual_channel, .output_latency,
    .converting);
  scc_ref_source src (.sys_clk, .rst, .run(ref_run), .ref_clk(ref_in));
  always #2.5 sys_clk = ~sys_clk;
  task automatic complete_run;
    $display("mismatches %0d samples_checked %0d", mismatches,
      samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // holds the request until pready is sampled high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, 32'(pready));
  endtask : apb
  task automatic settle;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic toggles(input logic [31:0] e);
    logic p;
    int c;
    settle();
    c = 0;
    p = reference_clock_output_one;
    repeat (16) begin
      @(posedge sys_clk);
      #1;
      if (reference_clock_output_one !== p) c++;
      p = reference_clock_output_one;
    end
    chk("ref toggles", e, 32'(c));
  endtask : toggles
  // secondary realigns to the incoming reference: phase code 2 puts the
  // output in step with it, code 0 in opposition
  task automatic follow(input logic inv);
    int c;
    c = 0;
    repeat (12) @(posedge sys_clk);
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      if (reference_clock_output_one !== (ref_in ^ inv)) c++;
    end
    chk("ref align", 32'h0, 32'(c));
  endtask : follow
  task automatic t_map;
    apb(0, 8'h34, 0);
    chk("fine", 32'h0, rd);
    apb(0, 8'h38, 0);
    chk("sync", 32'h3, rd);
    apb(1, 8'h3c, 32'hffff);
    apb(0, 8'h3c, 0);
    chk("reserved", 32'h1d, rd);
    apb(1, 8'h40, 32'h1);
    chk("slverr", 32'h1, 32'(err));
    settle();
    chk("clk reset", 32'h0, 32'(output_clock_reset));
  endtask : t_map
  task automatic t_fine;
    apb(1, 8'h30, 32'h1230);
    apb(1, 8'h34, 32'hfc00);
    settle();
    chk("fine off", 32'h0, 32'(fine_delay_magnitude));
    chk("coarse off", 32'h0, 32'(coarse_delay_code));
    apb(1, 8'h30, 32'h1238);
    settle();
    chk("coarse", 32'h123, 32'(coarse_delay_code));
    chk("fine mag", 32'h3f, 32'(fine_delay_magnitude));
    chk("fine fs", 32'h8dc, 32'(fine_delay_fs));
  endtask : t_fine
  task automatic t_sync;
    logic [8:0] dc [4] = '{9'h000, 9'h13e, 9'h13f, 9'h1ff};
    for (int k = 0; k < 4; k++) begin
      apb(1, 8'h38, (32'(dc[k]) << 7) | (32'(k) << 3) | 32'h3);
      settle();
      chk("ref delay", 32'(dc[k] > REF_DLY_MAX_CODE ? REF_DLY_MAX_CODE :
        dc[k]), 32'(reference_clock_delay));
      chk("phase", 32'(k), 32'(reference_phase_select));
    end
  endtask : t_sync
  task automatic t_roles;
    apb(1, 8'h38, 32'h1);
    toggles(32'h8);
    apb(1, 8'h04, 32'h1);
    toggles(32'h10);
    apb(1, 8'h04, 32'h0);
    ref_run <= 1'b1;
    apb(1, 8'h38, 32'h14);
    follow(1'b0);
    apb(1, 8'h38, 32'h4);
    follow(1'b1);
    apb(1, 8'h38, 32'h7);
    toggles(32'h0);
    chk("secondary", 32'h1, 32'(secondary_role_enable));
    apb(1, 8'h38, 32'h2);
    settle();
    chk("clk reset", 32'h1, 32'(output_clock_reset));
    ref_run <= 1'b0;
  endtask : t_roles
  task automatic t_edges;
    apb(1, 8'h00, 32'h0);
    apb(1, 8'h38, 32'h43);
    settle();
    chk("dual edge", 32'h1, 32'(dual_edge_mode));
    chk("q edge", 32'h0, 32'(q_sample_rising));
    chk("i edge", 32'h1, 32'(i_sample_rising));
    chk("two chan", 32'h0, 32'(dual_channel));
    chk("i used", 32'h1, 32'(i_input_used));
    chk("q used", 32'h1, 32'(q_input_used));
    apb(1, 8'h00, 32'h20);
    settle();
    chk("dual edge", 32'h0, 32'(dual_edge_mode));
    chk("q edge", 32'h1, 32'(q_sample_rising));
    chk("two chan", 32'h1, 32'(dual_channel));
    chk("i used", 32'h1, 32'(i_input_used));
    chk("q used", 32'h1, 32'(q_input_used));
  endtask : t_edges
  task automatic t_latency;
    logic [3:0] lat [3] = '{LAT_1TO1, LAT_1TO2, LAT_1TO4};
    for (int m = 0; m < 3; m++) begin
      apb(1, 8'h04, 32'(m) << 1);
      settle();
      chk("latency", 32'(lat[m]), 32'(output_latency));
    end
    @(posedge sys_clk);
    clock_present <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    chk("converting", 32'h0, 32'(converting));
  endtask : t_latency
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    clock_present <= 1'b1;
    t_map();
    t_fine();
    t_sync();
    t_roles();
    t_edges();
    t_latency();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    complete_run();
  end
endmodule : scc_top_bench
